// ### tcpq_timer.sv
`timescale 1ns/10ps
// What this block does
// - three non-overlapping output pairs from channels 3, 4
// - period register holds ch3 upper limit minus one
// - complementary mode alone makes pins outputs
// - both count up/down, reverse at match/underflow
// - transitions ordered ch3, ch4, ch4, ch3
// - turn above period holds 0% or 100%
// - match flag on increment, overflow on underflow
// - buffers copy at ch3 match up, ch4 underflow
// - channel 2 counts quadrature inputs up/down
// - count every edge, direction from other input
module tcpq_timer #(
    parameter int CNT_W = tcpq_pkg::CNT_W
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [tcpq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [tcpq_pkg::CNT_W-1:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [tcpq_pkg::CNT_W-1:0] RDATA,
    input wire logic QUAD_INPUT_A,
    input wire logic QUAD_INPUT_B,
    output tcpq_pkg::tcpq_pwm_t PWM_OUT
);
    import tcpq_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (CNT_W != tcpq_pkg::CNT_W) begin : g_width_check
        $error("tcpq_timer: counter width must match the register bus width");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] run_reg, run_next;
    logic [7:0] mode_reg, mode_next;
    logic [CNT_W-1:0] cnt3_reg, cnt3_next;
    logic [CNT_W-1:0] cnt4_reg, cnt4_next;
    logic [CNT_W-1:0] cnt2_reg, cnt2_next;
    logic [CNT_W-1:0] period_reg, period_next;
    logic [CNT_W-1:0] turn_reg [3];
    logic [CNT_W-1:0] turn_next [3];
    logic [CNT_W-1:0] buf_reg [3];
    logic [CNT_W-1:0] buf_next [3];
    logic [2:0] stat_reg, stat_next;
    logic down_reg, down_next;
    tcpq_pwm_t pwm_reg, pwm_next;
    logic qa_reg, qa_next;
    logic qb_reg, qb_next;
    logic [2:0] div_reg, div_next;
    logic [CNT_W-1:0] rdata_reg, rdata_next;

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    logic comp_mode;
    logic comp_run;
    logic phase_mode;
    logic tick;
    logic [2:0] psc_mask;
    logic match3_up;
    logic under4;
    logic [2:0] hit3;
    logic [2:0] hit4;
    logic a_rise, a_fall, b_rise, b_fall;
    logic quad_up, quad_dn;
    logic wr_run, wr_mode, wr_cnt3, wr_cnt4, wr_cnt2, wr_period, wr_stat;
    logic [2:0] wr_turn;
    logic [2:0] wr_buf;

    assign comp_mode = mode_reg[MODE_COMP_BIT];
    assign phase_mode = mode_reg[MODE_PHASE_BIT];
    // complementary counting needs both run bits; the pair shares one clock
    assign comp_run = comp_mode && run_reg[RUN_CH3_BIT] && run_reg[RUN_CH4_BIT];

    // prescaler enable: divide by 1, 2, 4 or 8
    assign psc_mask = 3'((4'h1 << mode_reg[MODE_PSC_LSB +: 2]) - 4'h1);
    assign tick = ((div_reg & psc_mask) == psc_mask);

    // reversal events of the complementary pair
    assign match3_up = comp_run && tick && !down_reg && (cnt3_reg == period_reg);
    assign under4 = comp_run && tick && down_reg && (cnt4_reg == CNT_RST);

    // register write decode
    assign wr_run = WR_EN && (ADDR == ADDR_RUN);
    assign wr_mode = WR_EN && (ADDR == ADDR_MODE);
    assign wr_cnt3 = WR_EN && (ADDR == ADDR_CNT3);
    assign wr_cnt4 = WR_EN && (ADDR == ADDR_CNT4);
    assign wr_cnt2 = WR_EN && (ADDR == ADDR_CNT2);
    assign wr_period = WR_EN && (ADDR == ADDR_PERIOD);
    assign wr_stat = WR_EN && (ADDR == ADDR_STAT);

    // quadrature edges; the inputs arrive synchronous to the clock
    assign a_rise = QUAD_INPUT_A && !qa_reg;
    assign a_fall = !QUAD_INPUT_A && qa_reg;
    assign b_rise = QUAD_INPUT_B && !qb_reg;
    assign b_fall = !QUAD_INPUT_B && qb_reg;
    // direction from the level of the other input
    assign quad_up = (b_rise && !QUAD_INPUT_A) || (a_rise && QUAD_INPUT_B)
                   || (b_fall && QUAD_INPUT_A) || (a_fall && !QUAD_INPUT_B);
    assign quad_dn = (b_rise && QUAD_INPUT_A) || (a_fall && QUAD_INPUT_B)
                   || (b_fall && !QUAD_INPUT_A) || (a_rise && !QUAD_INPUT_B);

    // ------------------------------------------------------------
    // per phase compare and register decode
    // ------------------------------------------------------------
    genvar k;
    for (k = 0; k < 3; k++) begin : g_phase
        // a turn value above the period never matches
        logic in_range;
        assign in_range = (turn_reg[k] <= period_reg);
        assign hit3[k] = comp_run && tick && in_range && (cnt3_reg == turn_reg[k]);
        assign hit4[k] = comp_run && tick && in_range && (cnt4_reg == turn_reg[k]);
        assign wr_turn[k] = WR_EN && (ADDR == ADDR_W'(ADDR_TURN1 + k));
        assign wr_buf[k] = WR_EN && (ADDR == ADDR_W'(ADDR_BUF1 + k));
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] st_set;
        st_set = 3'h0;
        run_next = wr_run ? WDATA[2:0] : run_reg;
        mode_next = wr_mode ? WDATA[7:0] : mode_reg;
        period_next = wr_period ? WDATA : period_reg;
        div_next = 3'(div_reg + 3'h1);
        qa_next = QUAD_INPUT_A;
        qb_next = QUAD_INPUT_B;
        down_next = down_reg;
        cnt3_next = cnt3_reg;
        cnt4_next = cnt4_reg;
        cnt2_next = cnt2_reg;

        // complementary up/down counting with overshoot and undershoot
        if (comp_run && tick) begin
            if (!down_reg) begin
                cnt3_next = cnt3_reg + 16'h0001;
                cnt4_next = cnt4_reg + 16'h0001;
                if (match3_up) begin
                    down_next = 1'b1;
                end
            end else begin
                cnt3_next = cnt3_reg - 16'h0001;
                cnt4_next = cnt4_reg - 16'h0001;
                if (under4) begin
                    down_next = 1'b0;
                end
            end
        end

        // phase counting or plain up count on channel 2
        if (run_reg[RUN_CH2_BIT]) begin
            if (phase_mode) begin
                if (quad_up) begin
                    cnt2_next = cnt2_reg + 16'h0001;
                    if (cnt2_reg == GR_RST && !mode_reg[MODE_DIRECTION_FLAG_COND_BIT]) begin
                        st_set[STAT_OVF2_BIT] = 1'b1;
                    end
                end else if (quad_dn) begin
                    cnt2_next = cnt2_reg - 16'h0001;
                    if (cnt2_reg == CNT_RST && mode_reg[MODE_DIRECTION_FLAG_COND_BIT]) begin
                        st_set[STAT_OVF2_BIT] = 1'b1;
                    end
                end
            end else if (tick) begin
                cnt2_next = cnt2_reg + 16'h0001;
                if (cnt2_reg == GR_RST && !mode_reg[MODE_DIRECTION_FLAG_COND_BIT]) begin
                    st_set[STAT_OVF2_BIT] = 1'b1;
                end
            end
        end

        // software writes to a counter take priority over counting
        if (wr_cnt3) begin
            cnt3_next = WDATA;
        end
        if (wr_cnt4) begin
            cnt4_next = WDATA;
        end
        if (wr_cnt2) begin
            cnt2_next = WDATA;
        end
        if (wr_run && !WDATA[RUN_CH3_BIT]) begin
            down_next = 1'b0;
        end

        // flags: ch3 match only when incrementing, ch4 overflow only on underflow
        st_set[STAT_MATCH3_BIT] = match3_up;
        st_set[STAT_OVF4_BIT] = under4;
        // write one to clear; a new event in the same cycle wins
        stat_next = (stat_reg & ~(wr_stat ? WDATA[2:0] : 3'h0)) | st_set;

        // buffer and turn registers
        for (int i = 0; i < 3; i++) begin
            buf_next[i] = wr_buf[i] ? WDATA : buf_reg[i];
            turn_next[i] = wr_turn[i] ? WDATA : turn_reg[i];
            if ((match3_up || under4) && mode_reg[MODE_BUF_LSB + i]) begin
                turn_next[i] = buf_reg[i];
            end
        end

    end

    // ------------------------------------------------------------
    // gate drive levels
    // ------------------------------------------------------------
    always_comb begin
        pwm_next = pwm_reg;
        // pairs follow the compare hits of both counters
        if (!comp_mode) begin
            pwm_next.pos = 3'h0;
            pwm_next.neg = 3'h0;
        end else if (wr_mode && !WDATA[MODE_COMP_BIT]) begin
            pwm_next.pos = 3'h0;
            pwm_next.neg = 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!down_reg) begin
                    // up: negative off at ch3, positive on at ch4
                    if (hit3[i]) begin
                        pwm_next.neg[i] = 1'b0;
                    end
                    if (hit4[i]) begin
                        pwm_next.pos[i] = 1'b1;
                    end
                end else begin
                    // down: positive off at ch4, negative on at ch3
                    if (hit4[i]) begin
                        pwm_next.pos[i] = 1'b0;
                    end
                    if (hit3[i]) begin
                        pwm_next.neg[i] = 1'b1;
                    end
                end
            end
        end
        // entering complementary mode parks each pair at negative on
        if (wr_mode && WDATA[MODE_COMP_BIT] && !comp_mode) begin
            pwm_next.pos = 3'h0;
            pwm_next.neg = 3'h7;
        end

    end

    // ------------------------------------------------------------
    // read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = '0;
        if (RD_EN) begin
            case (ADDR)
                ADDR_RUN: rdata_next = CNT_W'(run_reg);
                ADDR_MODE: rdata_next = CNT_W'(mode_reg);
                ADDR_CNT3: rdata_next = cnt3_reg;
                ADDR_CNT4: rdata_next = cnt4_reg;
                ADDR_CNT2: rdata_next = cnt2_reg;
                ADDR_PERIOD: rdata_next = period_reg;
                ADDR_TURN1: rdata_next = turn_reg[0];
                ADDR_W'(ADDR_TURN1 + 4'h1): rdata_next = turn_reg[1];
                ADDR_W'(ADDR_TURN1 + 4'h2): rdata_next = turn_reg[2];
                ADDR_BUF1: rdata_next = buf_reg[0];
                ADDR_W'(ADDR_BUF1 + 4'h1): rdata_next = buf_reg[1];
                ADDR_W'(ADDR_BUF1 + 4'h2): rdata_next = buf_reg[2];
                ADDR_STAT: rdata_next = CNT_W'({down_reg, stat_reg});
                default: rdata_next = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            run_reg <= RUN_RST;
            mode_reg <= MODE_RST;
            cnt3_reg <= CNT_RST;
            cnt4_reg <= CNT_RST;
            cnt2_reg <= CNT_RST;
            period_reg <= GR_RST;
            stat_reg <= STAT_RST;
            down_reg <= 1'b0;
            qa_reg <= 1'b0;
            qb_reg <= 1'b0;
            div_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                turn_reg[i] <= GR_RST;
                buf_reg[i] <= GR_RST;
            end
        end else begin
            run_reg <= run_next;
            mode_reg <= mode_next;
            cnt3_reg <= cnt3_next;
            cnt4_reg <= cnt4_next;
            cnt2_reg <= cnt2_next;
            period_reg <= period_next;
            stat_reg <= stat_next;
            down_reg <= down_next;
            qa_reg <= qa_next;
            qb_reg <= qb_next;
            div_reg <= div_next;
            for (int i = 0; i < 3; i++) begin
                turn_reg[i] <= turn_next[i];
                buf_reg[i] <= buf_next[i];
            end
        end
    end

    // gate drive register, reset parks every pin low
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pwm_reg <= '0;
        end else begin
            pwm_reg <= pwm_next;
        end
    end

    // read data register, zero outside its read cycle
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;
    assign PWM_OUT = pwm_reg;
endmodule : tcpq_timer

// ### tcpq_pkg.sv
package tcpq_pkg;
    // ------------------------------------------------------------
    // sizes and register map
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_RUN = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CNT3 = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CNT4 = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_CNT2 = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_TURN1 = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_BUF1 = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RUN_CH2_BIT = 0;
    localparam int RUN_CH3_BIT = 1;
    localparam int RUN_CH4_BIT = 2;
    localparam int MODE_COMP_BIT = 0;
    localparam int MODE_PHASE_BIT = 1;
    localparam int MODE_DIRECTION_FLAG_COND_BIT = 2;
    localparam int MODE_BUF_LSB = 3;
    localparam int MODE_PSC_LSB = 6;
    localparam int STAT_MATCH3_BIT = 0;
    localparam int STAT_OVF4_BIT = 1;
    localparam int STAT_OVF2_BIT = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RUN_RST = 3'h0;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hFFFF;
    localparam logic [2:0] STAT_RST = 3'h0;

    // six gate drive levels, one pair per phase
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
    } tcpq_pwm_t;
endpackage : tcpq_pkg

// ### tcpq_timer_props.sv
`timescale 1ns/10ps
module tcpq_timer_props (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [tcpq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [tcpq_pkg::CNT_W-1:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [tcpq_pkg::CNT_W-1:0] RDATA,
    input wire logic QUAD_INPUT_A,
    input wire logic QUAD_INPUT_B,
    input wire tcpq_pkg::tcpq_pwm_t PWM_OUT
);
    import tcpq_pkg::*;
    // ------------------------------------------------------------
    // shadow of mode and run bits, taken from bus writes
    // ------------------------------------------------------------
    logic mode_reg;
    logic [2:0] run_reg;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    // track what software last wrote
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            mode_reg <= 1'b0;
            run_reg <= 3'h0;
        end else if (WR_EN && ADDR == ADDR_MODE) begin
            mode_reg <= WDATA[MODE_COMP_BIT];
        end else if (WR_EN && ADDR == ADDR_RUN) begin
            run_reg <= WDATA[2:0];
        end
    end
    // waveform and read data relations
    a_pair_apart: assert property ((PWM_OUT.pos & PWM_OUT.neg) == 3'h0)
        else $error("positive and negative phase overlap");
    a_dead_pos: assert property ($rose(PWM_OUT.pos[0]) |-> !$past(PWM_OUT.neg[0]))
        else $error("positive phase rose without dead time");
    a_dead_neg: assert property ($rose(PWM_OUT.neg[0]) |-> !$past(PWM_OUT.pos[0]))
        else $error("negative phase rose without dead time");
    a_comp_on: assert property (WR_EN && ADDR == ADDR_MODE && WDATA[MODE_COMP_BIT] && !mode_reg
        |-> ##[1:2] (PWM_OUT.pos == 3'h0 && PWM_OUT.neg == 3'h7))
        else $error("outputs not taken over by complementary mode");
    a_comp_off: assert property (WR_EN && ADDR == ADDR_MODE && !WDATA[MODE_COMP_BIT]
        |-> ##[1:2] PWM_OUT == 6'h00)
        else $error("outputs not released when mode cleared");
    a_parked_off: assert property (!mode_reg && !$past(mode_reg) |-> PWM_OUT == 6'h00)
        else $error("outputs driven outside complementary mode");
    a_stopped_hold: assert property (run_reg[2:1] != 2'h3 && $past(run_reg[2:1]) != 2'h3
        && $past(run_reg[2:1], 2) != 2'h3 && mode_reg && $past(mode_reg)
        && $past(mode_reg, 2) |-> $stable(PWM_OUT))
        else $error("outputs moved with counters stopped");
    a_rdata_idle: assert property (!$past(RD_EN) |-> RDATA == 16'h0000)
        else $error("read data outside its cycle");
    a_hole_zero: assert property (RD_EN && ADDR >= 4'hD |=> RDATA == 16'h0000)
        else $error("unmapped read returned data");
endmodule : tcpq_timer_props

bind tcpq_timer tcpq_timer_props u_tcpq_timer_props (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
    .QUAD_INPUT_A(QUAD_INPUT_A), .QUAD_INPUT_B(QUAD_INPUT_B), .PWM_OUT(PWM_OUT));

// ### tcpq_enc_model.sv
`timescale 1ns/10ps
module tcpq_enc_model (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic signed [15:0] target,
    output logic quad_a,
    output logic quad_b,
    output logic done
);
    // ------------------------------------------------------------
    // encoder stepping towards the commanded position
    // ------------------------------------------------------------
    logic signed [15:0] pos_reg;
    logic [1:0] gap_reg;
    // one edge every four cycles keeps width and phase margins
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pos_reg <= 16'sh0000;
            gap_reg <= 2'h0;
        end else begin
            gap_reg <= gap_reg + 2'h1;
            if (gap_reg == 2'h3 && pos_reg != target) begin
                pos_reg <= (pos_reg < target) ? pos_reg + 16'sh0001 : pos_reg - 16'sh0001;
            end
        end
    end
    // gray code of the position, b leads a when moving up
    assign quad_a = pos_reg[1];
    assign quad_b = pos_reg[1] ^ pos_reg[0];
    assign done = (pos_reg == target);
endmodule : tcpq_enc_model

// ### tcpq_timer_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tcpq_timer_tb;
    import tcpq_pkg::*;
    // ------------------------------------------------------------
    // stimulus, partner and checks
    // ------------------------------------------------------------
    localparam logic [15:0] OFS = 16'h0002;
    logic CLOCK, SYS_RST, WR_EN, RD_EN, quad_a, quad_b, enc_done;
    logic [3:0] ADDR;
    logic [15:0] WDATA, RDATA, d;
    logic [5:0] pw;
    logic signed [15:0] target;
    tcpq_pwm_t PWM_OUT;
    int mismatches = 0;
    int checks = 0;
    int n;
    assign pw = PWM_OUT;
    tcpq_timer u_tcpq_timer (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .QUAD_INPUT_A(quad_a),
        .QUAD_INPUT_B(quad_b), .PWM_OUT(PWM_OUT));
    tcpq_enc_model u_tcpq_enc_model (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .target(target),
        .quad_a(quad_a), .quad_b(quad_b), .done(enc_done));
    // 250 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    // bus cycles, one strobe cycle each
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge CLOCK);
        ADDR <= a; WDATA <= v; WR_EN <= 1'b1;
        @(posedge CLOCK);
        WR_EN <= 1'b0;
    endtask : wr
    task rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLOCK);
        ADDR <= a; RD_EN <= 1'b1;
        @(posedge CLOCK);
        RD_EN <= 1'b0;
        #1 d = RDATA;
        `CHK(d, e)
    endtask : rc
    task summarize;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // bounded waits on an output bit or on the encoder
    task wait_bit(input int b, input logic lvl, output int cnt);
        cnt = 0;
        do begin @(posedge CLOCK); #1; cnt++; end while (pw[b] !== lvl && cnt < 200);
        if (cnt >= 200) begin mismatches++; summarize(); end
    endtask : wait_bit
    task enc(input logic signed [15:0] t);
        @(posedge CLOCK);
        target <= t;
        n = 0;
        do begin @(posedge CLOCK); #1; n++; end while (enc_done !== 1'b1 && n < 500);
        if (n >= 500) begin mismatches++; summarize(); end
        repeat (3) @(posedge CLOCK);
    endtask : enc
    // reset values, unmapped index ignored
    task t_reset;
        for (int i = 0; i < 13; i++) rc(i[3:0], (i >= 5 && i <= 11) ? 16'hFFFF : 16'h0000);
        wr(4'hD, 16'h1234);
        rc(4'hD, 16'h0000);
    endtask : t_reset
    // complementary pwm with dead time, buffer copy and flags
    task t_comp;
        wr(ADDR_CNT4, 16'h0000);
        wr(ADDR_CNT3, OFS);
        wr(ADDR_PERIOD, 16'h0005);
        wr(ADDR_TURN1, 16'h0003);
        wr(ADDR_BUF1, 16'h0002);
        wr(ADDR_MODE, 16'h0009);
        repeat (2) @(posedge CLOCK);
        #1 `CHK(pw, 6'h07)
        wr(ADDR_RUN, 16'h0006);
        wait_bit(0, 1'b0, n);
        wait_bit(3, 1'b1, n);
        `CHK(n, OFS)
        wait_bit(3, 1'b0, n);
        wait_bit(0, 1'b1, n);
        `CHK(n, OFS)
        `CHK({pw[4], pw[1]}, 2'h1)
        `CHK({pw[5], pw[2]}, 2'h1)
        wait_bit(0, 1'b0, n);
        wr(ADDR_RUN, 16'h0000);
        rc(ADDR_STAT, 16'h0003);
        rc(ADDR_TURN1, 16'h0002);
        wr(ADDR_STAT, 16'h0003);
        rc(ADDR_STAT, 16'h0000);
        wr(ADDR_MODE, 16'h0000);
        repeat (2) @(posedge CLOCK);
        #1 `CHK(pw, 6'h00)
    endtask : t_comp
    // quadrature counting both ways through zero
    task t_phase;
        wr(ADDR_MODE, 16'h0006);
        wr(ADDR_RUN, 16'h0001);
        enc(16'sh0004);
        rc(ADDR_CNT2, 16'h0004);
        enc(-16'sh0002);
        rc(ADDR_CNT2, 16'hFFFE);
        rc(ADDR_STAT, 16'h0004);
    endtask : t_phase
    // plain channel 2 count at half rate, overflow flag on wrap
    task t_plain;
        wr(ADDR_RUN, 16'h0000);
        wr(ADDR_STAT, 16'h0004);
        wr(ADDR_MODE, 16'h0040);
        wr(ADDR_CNT2, 16'hFFFE);
        wr(ADDR_RUN, 16'h0001);
        repeat (4) @(posedge CLOCK);
        wr(ADDR_RUN, 16'h0000);
        rc(ADDR_CNT2, 16'h0001);
        rc(ADDR_STAT, 16'h0004);
    endtask : t_plain
    // main sequence
    initial begin
        SYS_RST = 1'b1; WR_EN = 1'b0; RD_EN = 1'b0;
        ADDR = 4'h0; WDATA = 16'h0000; target = 16'sh0000;
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        t_reset();
        t_comp();
        t_phase();
        t_plain();
        summarize();
    end
endmodule : tcpq_timer_tb
